// ### verilog/spi_flags_pkg.sv
package spi_flags_pkg;

    // register port geometry
    localparam int unsigned ADDR_W = 8;
    localparam int unsigned DATA_W = 8;

    // register byte offsets
    localparam logic [7:0] OFS_CONTROL    = 8'hBC;
    localparam logic [7:0] OFS_FLAGS      = 8'hBD;
    localparam logic [7:0] OFS_DATA       = 8'hBE;
    localparam logic [7:0] OFS_IRQ_STATUS = 8'hBF;
    localparam logic [7:0] OFS_IRQ_MASK   = 8'hC0;

    // serial_port_flags bit positions
    localparam int unsigned BIT_CONFLICT = 5;
    localparam int unsigned BIT_OVERRUN  = 4;
    localparam int unsigned BIT_RX_FULL  = 3;
    localparam int unsigned BIT_ACTIVE   = 2;

    // port_control_register bit positions
    localparam int unsigned CTL_ENABLE     = 6;
    localparam int unsigned CTL_SEL_DIS    = 5;
    localparam int unsigned CTL_CONTROLLER = 4;

    // interrupt status / mask bit positions
    localparam int unsigned EV_CONFLICT = 0;
    localparam int unsigned EV_RX_FULL  = 1;
    localparam int unsigned EV_OVERRUN  = 2;
    localparam int unsigned EV_W        = 3;

    // values after reset
    localparam logic [7:0] RST_CONTROL = 8'h00;
    localparam logic [7:0] RST_DATA    = 8'h00;
    localparam logic [2:0] RST_EVENTS  = 3'h0;

    // shift engine towards this block
    typedef struct packed {
        logic       busy;    // transfer in progress
        logic       done;    // one-cycle end of transfer
        logic [7:0] rx_byte; // byte received, valid with done
    } xfer_in_s;

    // this block towards the shift engine
    typedef struct packed {
        logic       port_enable;       // port switched on
        logic       controller_select; // master operation
        logic       sel_input_disable; // select pin ignored
        logic [7:0] control;           // whole control byte
        logic       tx_load;           // one-cycle new byte
        logic [7:0] tx_byte;           // byte to transmit
    } xfer_out_s;

endpackage

// ### verilog/sticky_bit.sv
`timescale 1ns/1ps

// one flag that hardware sets and software clears
module sticky_bit (
    input  wire logic core_clk, // system clock
    input  wire logic rst,      // sync reset, high
    input  wire logic set,      // hardware set event
    input  wire logic clr,      // software clear
    output logic      q         // flag value
);

    // set beats clear in the same cycle
    always_ff @(posedge core_clk) begin
        if (rst) begin
            q <= 1'b0;
        end else if (set) begin
            q <= 1'b1;
        end else if (clr) begin
            q <= 1'b0;
        end
    end

endmodule

// ### verilog/spi_status_flags.sv
`timescale 1ns/1ps


module spi_status_flags (
    input  wire logic                     core_clk,  // system clock
    input  wire logic                     rst,       // sync reset, high
    input  wire logic [7:0]               reg_addr,  // register address
    input  wire logic [7:0]               reg_wdata, // write data
    input  wire logic                     reg_wr,    // write strobe
    input  wire logic                     reg_rd,    // read strobe
    output logic      [7:0]               reg_rdata, // read data, next cycle
    input  wire logic                     sel_n,     // select pin level
    input  wire spi_flags_pkg::xfer_in_s  xfer_in,   // from shift engine
    output spi_flags_pkg::xfer_out_s      xfer_out,  // to shift engine
    output logic                          irq        // level interrupt
);

    ////////////////////////////////////////////////////////////////
    // address decode
    ////////////////////////////////////////////////////////////////

    // write strobes per register
    logic wr_control;
    logic wr_flags;
    logic wr_data;
    logic wr_mask;
    // read strobes with side effects
    logic rd_data;
    logic rd_status;

    assign wr_control = reg_wr && (reg_addr == spi_flags_pkg::OFS_CONTROL);
    assign wr_flags   = reg_wr && (reg_addr == spi_flags_pkg::OFS_FLAGS);
    assign wr_data    = reg_wr && (reg_addr == spi_flags_pkg::OFS_DATA);
    assign wr_mask    = reg_wr && (reg_addr == spi_flags_pkg::OFS_IRQ_MASK);
    assign rd_data    = reg_rd && (reg_addr == spi_flags_pkg::OFS_DATA);
    assign rd_status  = reg_rd && (reg_addr == spi_flags_pkg::OFS_IRQ_STATUS);

    ////////////////////////////////////////////////////////////////
    // port control register
    ////////////////////////////////////////////////////////////////

    // stored control byte
    logic [7:0] control_r;
    // conflict set event, see below
    logic       conflict_set;

    // software writes, conflict forces port off
    always_ff @(posedge core_clk) begin
        if (rst) begin
            control_r <= spi_flags_pkg::RST_CONTROL;
        end else begin
            if (wr_control) begin
                control_r <= reg_wdata;
            end
            // overrides a write in the same cycle
            if (conflict_set) begin
                control_r[spi_flags_pkg::CTL_ENABLE]     <= 1'b0;
                control_r[spi_flags_pkg::CTL_CONTROLLER] <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////
    // bus conflict flag
    ////////////////////////////////////////////////////////////////

    // flag outputs of the sticky cells
    logic bus_conflict_flag;
    logic rx_full_flag;
    logic rx_overrun_flag;
    // software clears by writing zero, receive flags also by a data read
    logic clr_conflict;
    logic clr_full;
    logic clr_overrun;

    // another master pulls select low while we lead
    assign conflict_set = control_r[spi_flags_pkg::CTL_ENABLE]
                        && control_r[spi_flags_pkg::CTL_CONTROLLER]
                        && !control_r[spi_flags_pkg::CTL_SEL_DIS]
                        && !sel_n;

    // a zero written to the bit clears it
    assign clr_conflict = wr_flags && !reg_wdata[spi_flags_pkg::BIT_CONFLICT];

    // conflict flag cell
    sticky_bit u_conflict (
        .core_clk (core_clk),
        .rst      (rst),
        .set      (conflict_set),
        .clr      (clr_conflict),
        .q        (bus_conflict_flag)
    );

    ////////////////////////////////////////////////////////////////
    // receive flags
    ////////////////////////////////////////////////////////////////

    // overrun when a byte lands on a full buffer
    logic overrun_set;

    assign overrun_set = xfer_in.done && rx_full_flag;

    // zero write or data read empties the buffer
    assign clr_full    = (wr_flags && !reg_wdata[spi_flags_pkg::BIT_RX_FULL])
                       || rd_data;
    assign clr_overrun = (wr_flags && !reg_wdata[spi_flags_pkg::BIT_OVERRUN])
                       || rd_data;

    // receive full cell, set at every transfer end
    sticky_bit u_rx_full (
        .core_clk (core_clk),
        .rst      (rst),
        .set      (xfer_in.done),
        .clr      (clr_full),
        .q        (rx_full_flag)
    );

    // overrun cell
    sticky_bit u_overrun (
        .core_clk (core_clk),
        .rst      (rst),
        .set      (overrun_set),
        .clr      (clr_overrun),
        .q        (rx_overrun_flag)
    );

    ////////////////////////////////////////////////////////////////
    // transfer active flag
    ////////////////////////////////////////////////////////////////

    // mirrors the engine, no software path
    logic transfer_active_flag;

    // follows busy one cycle later
    always_ff @(posedge core_clk) begin
        if (rst) begin
            transfer_active_flag <= 1'b0;
        end else begin
            transfer_active_flag <= xfer_in.busy;
        end
    end

    ////////////////////////////////////////////////////////////////
    // shared data register
    ////////////////////////////////////////////////////////////////

    // received byte
    logic [7:0] rx_data_r;
    // byte to transmit
    logic [7:0] tx_data_r;
    // pulse telling the engine a byte waits
    logic       tx_load_r;

    // receive side: newest byte always kept
    always_ff @(posedge core_clk) begin
        if (rst) begin
            rx_data_r <= spi_flags_pkg::RST_DATA;
        end else if (xfer_in.done) begin
            rx_data_r <= xfer_in.rx_byte;
        end
    end

    // transmit side: write stores and loads
    always_ff @(posedge core_clk) begin
        if (rst) begin
            tx_data_r <= spi_flags_pkg::RST_DATA;
            tx_load_r <= 1'b0;
        end else begin
            tx_load_r <= wr_data;
            if (wr_data) begin
                tx_data_r <= reg_wdata;
            end
        end
    end

    ////////////////////////////////////////////////////////////////
    // interrupt status and mask
    ////////////////////////////////////////////////////////////////

    // event set pulses
    logic [spi_flags_pkg::EV_W-1:0] ev_set;
    // sticky status bits
    logic [spi_flags_pkg::EV_W-1:0] ev_status;
    // mask, one enables the source
    logic [spi_flags_pkg::EV_W-1:0] ev_mask_r;

    assign ev_set[spi_flags_pkg::EV_CONFLICT] = conflict_set;
    assign ev_set[spi_flags_pkg::EV_RX_FULL]  = xfer_in.done;
    assign ev_set[spi_flags_pkg::EV_OVERRUN]  = overrun_set;

    // one cell per event, read of status clears
    genvar gi;
    generate
        for (gi = 0; gi < spi_flags_pkg::EV_W; gi++) begin : g_ev
            sticky_bit u_ev (
                .core_clk (core_clk),
                .rst      (rst),
                .set      (ev_set[gi]),
                .clr      (rd_status),
                .q        (ev_status[gi])
            );
        end
    endgenerate

    // mask register
    always_ff @(posedge core_clk) begin
        if (rst) begin
            ev_mask_r <= spi_flags_pkg::RST_EVENTS;
        end else if (wr_mask) begin
            ev_mask_r <= reg_wdata[spi_flags_pkg::EV_W-1:0];
        end
    end

    // level output while any unmasked bit is set
    assign irq = |(ev_status & ev_mask_r);

    ////////////////////////////////////////////////////////////////
    // read data
    ////////////////////////////////////////////////////////////////

    // assembled flags byte, reserved bits zero
    logic [7:0] flags_view;

    always_comb begin
        flags_view = 8'h00;
        flags_view[spi_flags_pkg::BIT_CONFLICT] = bus_conflict_flag;
        flags_view[spi_flags_pkg::BIT_OVERRUN]  = rx_overrun_flag;
        flags_view[spi_flags_pkg::BIT_RX_FULL]  = rx_full_flag;
        flags_view[spi_flags_pkg::BIT_ACTIVE]   = transfer_active_flag;
    end

    // read mux, registered, zero when idle or unmapped
    always_ff @(posedge core_clk) begin
        if (rst) begin
            reg_rdata <= 8'h00;
        end else if (reg_rd) begin
            case (reg_addr)
                spi_flags_pkg::OFS_CONTROL: begin
                    reg_rdata <= control_r;
                end
                spi_flags_pkg::OFS_FLAGS: begin
                    reg_rdata <= flags_view;
                end
                spi_flags_pkg::OFS_DATA: begin
                    reg_rdata <= rx_data_r;
                end
                spi_flags_pkg::OFS_IRQ_STATUS: begin
                    reg_rdata <= {5'h00, ev_status};
                end
                spi_flags_pkg::OFS_IRQ_MASK: begin
                    reg_rdata <= {5'h00, ev_mask_r};
                end
                default: begin
                    reg_rdata <= 8'h00;
                end
            endcase
        end else begin
            reg_rdata <= 8'h00;
        end
    end

    ////////////////////////////////////////////////////////////////
    // outputs to the shift engine
    ////////////////////////////////////////////////////////////////

    assign xfer_out.port_enable       = control_r[spi_flags_pkg::CTL_ENABLE];
    assign xfer_out.controller_select = control_r[spi_flags_pkg::CTL_CONTROLLER];
    assign xfer_out.sel_input_disable = control_r[spi_flags_pkg::CTL_SEL_DIS];
    assign xfer_out.control           = control_r;
    assign xfer_out.tx_load           = tx_load_r;
    assign xfer_out.tx_byte           = tx_data_r;

    ////////////////////////////////////////////////////////////////
    // checks
    ////////////////////////////////////////////////////////////////

    default clocking cb @(posedge core_clk);
    endclocking

    default disable iff (rst);

    // a read of the data register
    sequence s_data_read;
        rd_data;
    endsequence

    // a zero written to the full bit or a data read, no byte arriving
    sequence s_full_zero_write;
        clr_full && !xfer_in.done;
    endsequence

    // conflict condition seen
    sequence s_conflict;
        conflict_set;
    endsequence

    // conflict raises the flag
    AST_CONFLICT_SETS: assert property (
        s_conflict |=> bus_conflict_flag
    ) else $error("conflict flag not set");

    // conflict drops port out of master operation
    AST_CONFLICT_DROPS_PORT: assert property (
        s_conflict |=> !xfer_out.port_enable && !xfer_out.controller_select
    ) else $error("port not dropped on conflict");

    // flag holds until a zero write
    AST_CONFLICT_HOLDS: assert property (
        bus_conflict_flag && !clr_conflict |=> bus_conflict_flag
    ) else $error("conflict flag lost");

    // zero write clears the conflict flag
    AST_CONFLICT_CLEARS: assert property (
        clr_conflict && !conflict_set |=> !bus_conflict_flag
    ) else $error("conflict flag not cleared");

    // byte on a full buffer gives overrun
    AST_OVERRUN_SETS: assert property (
        xfer_in.done && rx_full_flag |=> rx_overrun_flag
    ) else $error("overrun not set");

    // data read empties overrun
    AST_OVERRUN_CLEARS: assert property (
        s_data_read ##0 !overrun_set |=> !rx_overrun_flag
    ) else $error("overrun not cleared by read");

    // every transfer end marks the buffer full
    AST_FULL_SETS: assert property (
        xfer_in.done |=> rx_full_flag
    ) else $error("full flag not set");

    // zero write or read empties the buffer
    AST_FULL_CLEARS: assert property (
        s_full_zero_write |=> !rx_full_flag
    ) else $error("full flag not cleared");

    // active flag tracks busy with one cycle lag
    AST_ACTIVE_TRACKS: assert property (
        ##1 transfer_active_flag == $past(xfer_in.busy)
    ) else $error("active flag wrong");

    // data read returns the received byte
    AST_DATA_READBACK: assert property (
        s_data_read |=> reg_rdata == $past(rx_data_r)
    ) else $error("data read mismatch");

    // set beats a clear arriving together
    AST_SET_WINS: assert property (
        xfer_in.done && clr_full |=> rx_full_flag
    ) else $error("clear beat set");

endmodule

// ### tb/spi_peer_model.sv
`timescale 1ns/1ps

////////////////////////////////////////////////////////////////////////////////
// far side: one transfer per start pulse, done after a set number of cycles
module spi_peer_model (
    input  wire logic                core_clk, // system clock
    input  wire logic                rst,      // sync reset, high
    input  wire logic                start,    // begin one transfer
    input  wire logic [7:0]          len,      // busy cycles before done, less one
    input  wire logic [7:0]          byte_in,  // byte handed back at done
    output spi_flags_pkg::xfer_in_s  xfer_in   // towards the block
);
    logic [7:0] cnt_r; // cycles left in transfer

    // busy level, done pulse, byte valid only with done
    always_ff @(posedge core_clk) begin
        if (rst) begin
            xfer_in <= '0;
            cnt_r   <= 8'h00;
        end else begin
            xfer_in.done    <= 1'b0;
            // stale byte keeps changing, so nobody relies on it
            xfer_in.rx_byte <= ~xfer_in.rx_byte;
            if (start) begin
                xfer_in.busy <= 1'b1;
                cnt_r        <= len;
            end else if (xfer_in.busy) begin
                if (cnt_r == 8'h00) begin
                    xfer_in.busy    <= 1'b0;
                    xfer_in.done    <= 1'b1;
                    xfer_in.rx_byte <= byte_in;
                end else begin
                    cnt_r <= cnt_r - 8'h01;
                end
            end
        end
    end
endmodule

// ### tb/spi_status_flags_tb_top.sv
`timescale 1ns/1ps

////////////////////////////////////////////////////////////////////////////////
module spi_status_flags_tb_top;
    logic                      core_clk;  // 200 MHz clock
    logic                      rst;       // sync reset
    logic [7:0]                reg_addr;  // register address
    logic [7:0]                reg_wdata; // write data
    logic                      reg_wr;    // write strobe
    logic                      reg_rd;    // read strobe
    logic [7:0]                reg_rdata; // read data
    logic                      sel_n;     // select pin, idle high
    logic                      start;     // peer transfer start
    logic [7:0]                len;       // peer transfer length
    logic [7:0]                pbyte;     // peer byte
    logic [7:0]                d;         // last read value
    logic                      irq;       // interrupt line
    int                        errors;    // mismatches
    int                        cmp_count; // comparisons
    spi_flags_pkg::xfer_in_s   xfer_in;   // peer to block
    spi_flags_pkg::xfer_out_s  xfer_out;  // block to engine

    spi_status_flags u_spi_status_flags (.core_clk(core_clk), .rst(rst),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_rdata(reg_rdata), .sel_n(sel_n),
        .xfer_in(xfer_in), .xfer_out(xfer_out), .irq(irq));
    spi_peer_model u_spi_peer_model (.core_clk(core_clk), .rst(rst),
        .start(start), .len(len), .byte_in(pbyte), .xfer_in(xfer_in));

    ////////////////////////////////////////////////////////////////////////////
    // clock generation
    initial begin
        core_clk = 1'b0;
        forever #2.5 core_clk = ~core_clk;
    end

    // verdict and end of run
    task automatic summarize();
        $display("errors=%0d comparisons=%0d", errors, cmp_count);
        if (errors == 0 && cmp_count > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    // byte compare
    task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string m);
        cmp_count++;
        if (got !== exp) begin
            errors++;
            $display("CHECK FAILED t=%0t %s got %h exp %h", $time, m, got, exp);
        end
    endtask

    // register write, one strobe cycle
    task automatic wr(input logic [7:0] a, input logic [7:0] v);
        reg_addr  <= a;
        reg_wdata <= v;
        reg_wr    <= 1'b1;
        @(posedge core_clk);
        reg_wr    <= 1'b0;
    endtask

    // register read, data sampled the cycle after the strobe
    task automatic rd(input logic [7:0] a);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge core_clk);
        reg_rd   <= 1'b0;
        @(negedge core_clk);
        d = reg_rdata;
        @(posedge core_clk);
    endtask

    // start a peer transfer
    task automatic xfer(input logic [7:0] l, input logic [7:0] b);
        len   <= l;
        pbyte <= b;
        start <= 1'b1;
        @(posedge core_clk);
        start <= 1'b0;
    endtask

    // bounded wait for done, then one edge for the flags to land
    task automatic wait_done();
        int n;
        n = 0;
        while (xfer_in.done !== 1'b1 && n < 40) begin
            @(posedge core_clk);
            n++;
        end
        if (n >= 40) begin
            errors++;
            $display("CHECK FAILED t=%0t no done", $time);
            summarize();
        end else begin
            @(posedge core_clk);
        end
    endtask

    ////////////////////////////////////////////////////////////////////////////
    // transfer, active flag, data register both ways
    task automatic sc_transfer();
        int p;
        p = 0;
        wr(spi_flags_pkg::OFS_DATA, 8'h3C);
        repeat (3) begin
            @(negedge core_clk);
            p += int'(xfer_out.tx_load);
        end
        chk(8'(p), 8'h01, "tx_load pulses");
        chk(xfer_out.tx_byte, 8'h3C, "tx byte");
        @(posedge core_clk);
        xfer(8'h08, 8'hA5);
        repeat (2) @(posedge core_clk);
        rd(spi_flags_pkg::OFS_FLAGS);
        chk(d & 8'h3C, 8'h04, "active");
        wait_done();
        rd(spi_flags_pkg::OFS_FLAGS);
        chk(d & 8'h3C, 8'h08, "full set");
        chk({7'h00, irq}, 8'h00, "irq masked");
        rd(spi_flags_pkg::OFS_DATA);
        chk(d, 8'hA5, "rx byte");
        rd(spi_flags_pkg::OFS_FLAGS);
        chk(d & 8'h3C, 8'h00, "full read clear");
    endtask

    // overrun set and both clears, write-one and read-only bit ignored
    task automatic sc_overrun();
        xfer(8'h00, 8'h11);
        wait_done();
        xfer(8'h00, 8'h22);
        wait_done();
        wr(spi_flags_pkg::OFS_FLAGS, 8'hFF);
        rd(spi_flags_pkg::OFS_FLAGS);
        chk(d & 8'h3C, 8'h18, "overrun");
        rd(spi_flags_pkg::OFS_DATA);
        chk(d, 8'h22, "overwrite");
        rd(spi_flags_pkg::OFS_FLAGS);
        chk(d & 8'h3C, 8'h00, "read clear");
        xfer(8'h00, 8'h33);
        wait_done();
        xfer(8'h00, 8'h44);
        wait_done();
        wr(spi_flags_pkg::OFS_FLAGS, 8'h00);
        rd(spi_flags_pkg::OFS_FLAGS);
        chk(d & 8'h3C, 8'h00, "zero clear");
        // done lands in the same cycle as the clearing write
        xfer(8'h00, 8'h55);
        @(posedge core_clk);
        wr(spi_flags_pkg::OFS_FLAGS, 8'h00);
        rd(spi_flags_pkg::OFS_FLAGS);
        chk(d & 8'h3C, 8'h08, "set wins");
        wr(spi_flags_pkg::OFS_FLAGS, 8'h00);
    endtask

    // bus conflict: disabled detection, then fault, shutdown, clear
    task automatic sc_conflict();
        // let the previous write strobe drop before the next one
        @(posedge core_clk);
        sel_n <= 1'b0;
        wr(spi_flags_pkg::OFS_CONTROL, 8'h70);
        rd(spi_flags_pkg::OFS_CONTROL);
        chk(d, 8'h70, "disabled no fault");
        chk(xfer_out.control, 8'h70, "control out");
        chk({5'h00, xfer_out.port_enable, xfer_out.sel_input_disable,
             xfer_out.controller_select}, 8'h07, "control bits");
        rd(spi_flags_pkg::OFS_FLAGS);
        chk(d & 8'h3C, 8'h00, "no flag when disabled");
        wr(spi_flags_pkg::OFS_CONTROL, 8'h50);
        // flag lands one edge after the condition is seen
        @(posedge core_clk);
        rd(spi_flags_pkg::OFS_FLAGS);
        chk(d & 8'h3C, 8'h20, "conflict");
        rd(spi_flags_pkg::OFS_CONTROL);
        chk(d, 8'h00, "shutdown");
        chk({5'h00, xfer_out.port_enable, xfer_out.sel_input_disable,
             xfer_out.controller_select}, 8'h00, "port off");
        sel_n <= 1'b1;
        wr(spi_flags_pkg::OFS_FLAGS, 8'hFF);
        rd(spi_flags_pkg::OFS_FLAGS);
        chk(d & 8'h3C, 8'h20, "sticky");
        wr(spi_flags_pkg::OFS_FLAGS, 8'h00);
        rd(spi_flags_pkg::OFS_FLAGS);
        chk(d & 8'h3C, 8'h00, "zero clear");
    endtask

    // interrupt status, mask and read clear
    task automatic sc_irq();
        rd(spi_flags_pkg::OFS_IRQ_STATUS);
        xfer(8'h00, 8'h66);
        wait_done();
        wr(spi_flags_pkg::OFS_IRQ_MASK, 8'h02);
        @(negedge core_clk);
        chk({7'h00, irq}, 8'h01, "irq up");
        @(posedge core_clk);
        rd(spi_flags_pkg::OFS_IRQ_STATUS);
        chk(d, 8'h02, "status");
        chk({7'h00, irq}, 8'h00, "irq cleared");
        rd(8'hC8);
        chk(d, 8'h00, "unmapped");
    endtask

    ////////////////////////////////////////////////////////////////////////////
    // main sequence
    initial begin
        errors    = 0;
        cmp_count = 0;
        rst       = 1'b1;
        reg_addr  = 8'h00;
        reg_wdata = 8'h00;
        reg_wr    = 1'b0;
        reg_rd    = 1'b0;
        sel_n     = 1'b1;
        start     = 1'b0;
        len       = 8'h00;
        pbyte     = 8'h00;
        repeat (3) @(posedge core_clk);
        rst <= 1'b0;
        @(posedge core_clk);
        rd(spi_flags_pkg::OFS_FLAGS);
        chk(d, 8'h00, "flags reset");
        sc_transfer();
        sc_overrun();
        sc_conflict();
        sc_irq();
        summarize();
    end
endmodule
